// File: itc_consts.vh
// Constants for the I2C transfer controller: field positions, bus timing, counts.
// Assumes inclusion by bare name from the core file.
`ifndef ITC_CONSTS_VH
`define ITC_CONSTS_VH
`define ITC_FIFO_DEPTH     4
`define ITC_FIFO_AW        2
`define ITC_CMD_READ_BIT   8
`define ITC_CMD_STOP_BIT   9
`define ITC_STAT_RX_NOT_EMPTY_FLAG_BIT  3
`define ITC_RAW_RDREQ_BIT  5
`define ITC_RAW_TXABRT_BIT 6
`define ITC_RAW_RXFULL_BIT 2
`define ITC_CON_MASTER_BIT 0
`define ITC_CON_SPEED_HI   2
`define ITC_CON_SPEED_LO   1
`define ITC_CON_ADDR10_BIT 4
`define ITC_CON_SLVOFF_BIT 6
`define ITC_CAUSE_SW_BIT   16
`define ITC_TAR_ADDR_HI    9
`define ITC_TAR_GC_BIT     10
`define ITC_TAR_SPECIAL    11
`define ITC_HALF_BIT_NS    40
`define ITC_CLK_NS         5
`define ITC_HALF_BIT_CYC   ((`ITC_HALF_BIT_NS + `ITC_CLK_NS - 1) / `ITC_CLK_NS)
`endif

// File: itc_core.v
// I2C transfer controller: slave receive/transmit flow, master command stream, disable and abort.
// Assumes SCL/SDA arrive asynchronously; each pin is input, output, output enable (low drive).
// Notes on behaviour
// - Slave receive with full FIFO stretches SCL low until space frees.
// - Status bit 3 shows receive FIFO not empty; raw receive-full flag too.
// - Reading data/command returns oldest received byte in bits 7:0 and pops.
// - Slave transmit, ACK with empty TX FIFO: hold SCL, raise read request.
// - Read request sits at raw status bit five, independent of mask.
// - Slave sends back-to-back without stretching while ACK and data remain.
// - ACK of last FIFO byte raises read request again.
// - NACK with bytes queued discards leftovers and signals transmit abort.
// - Flush request is resampled in the core clock domain before clearing TX FIFO.
// - Target address holds 10-bit address plus general-call or start-byte select; core sends only bits 6:0 as a 7-bit address.
// - FIFOs held cleared while disabled; earlier writes are lost.
// - Enabled master with queued command sends START and address byte.
// - Command bit 8 zero writes low byte; one reads, low byte ignored.
// - Master keeps issuing queued reads and writes without software.
// - FIFO empty: stop flag gives STOP, else hold SCL low for next command.
// - Enable-status bit 0 stays high until shutdown completes.
// - Disable without stop flag stays active holding SCL until new command.
// - Abort in master mode issues STOP then flushes; ignored in slave mode.
// - Abort completion raises transmit abort with software-abort cause.
// - After transmit abort TX FIFO held flushed until abort-clear read.
`include "itc_consts.vh"
module itc_core (
    input  wire        clk_i,
    input  wire        rst_b_i,
    input  wire [6:0]  control_config_reg_i,
    input  wire        enable_i,
    input  wire        abort_i,
    input  wire [11:0] target_address_reg_i,
    input  wire [9:0]  own_address_reg_i,
    input  wire [9:0]  cmd_wdata_i,
    input  wire        cmd_write_i,
    input  wire        data_read_i,
    input  wire        abort_clear_read_i,
    input  wire        rd_req_clear_i,
    input  wire        scl_i,
    input  wire        sda_i,
    output wire        scl_o,
    output wire        scl_oe_o,
    output wire        sda_o,
    output wire        sda_oe_o,
    output reg  [7:0]  rx_data_o,
    output wire [7:0]  status_reg_o,
    output wire [7:0]  raw_irq_status_reg_o,
    output reg  [16:0] abort_cause_reg_o,
    output wire        enable_state_reg_o,
    output wire        tx_ready_o
);
    localparam [3:0] S_IDLE = 4'h0, S_START = 4'h1, S_BIT = 4'h2, S_ACK = 4'h3, S_HOLD = 4'h4;
    localparam [3:0] S_STOP = 4'h5, S_SADDR = 4'h6, S_SRX = 4'h7, S_STX = 4'h8, S_SWAIT = 4'h9;
    localparam [3:0] S_RSTR = 4'hA;
    localparam integer HB_CYC = `ITC_HALF_BIT_CYC;
    localparam [7:0] HB = HB_CYC[7:0];
    wire master = control_config_reg_i[`ITC_CON_MASTER_BIT] & control_config_reg_i[`ITC_CON_SLVOFF_BIT];
    // Pin synchronisers
    reg [1:0] scl_s, sda_s;
    reg       scl_d, sda_d;
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], scl_i};
            sda_s <= {sda_s[0], sda_i};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end
    wire scl = scl_s[1];
    wire sda = sda_s[1];
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire bus_start = scl & scl_d & sda_d & ~sda;
    wire bus_stop = scl & scl_d & ~sda_d & sda;
    // FIFOs
    reg [9:0] tx_mem [0:`ITC_FIFO_DEPTH-1];
    reg [7:0] rx_mem [0:`ITC_FIFO_DEPTH-1];
    reg [`ITC_FIFO_AW:0] tx_wp, tx_rp, rx_wp, rx_rp;
    reg        abort_hold, rd_req, tx_abort_irq_flag, flush_tgl, flush_s1, flush_s2, flush_s3;
    reg        tx_pop, rx_push, stretch, drive_sda, abort_req, abort_stop;
    reg [7:0]  shreg, rx_byte;
    reg [3:0]  state;
    reg [3:0]  nbits;
    reg [7:0]  cnt;
    reg [9:0]  cur;
    reg        phase, active, sda_out, scl_low, is_read, addr_phase;
    wire tx_empty = (tx_wp == tx_rp);
    wire tx_full = (tx_wp[`ITC_FIFO_AW] != tx_rp[`ITC_FIFO_AW]) &&
                   (tx_wp[`ITC_FIFO_AW-1:0] == tx_rp[`ITC_FIFO_AW-1:0]);
    wire rx_empty = (rx_wp == rx_rp);
    wire rx_full = (rx_wp[`ITC_FIFO_AW] != rx_rp[`ITC_FIFO_AW]) &&
                   (rx_wp[`ITC_FIFO_AW-1:0] == rx_rp[`ITC_FIFO_AW-1:0]);
    wire flush_evt = flush_s2 ^ flush_s3;
    wire tx_clear = ~enable_i | abort_hold | flush_evt;
    wire [9:0] tx_head = tx_mem[tx_rp[`ITC_FIFO_AW-1:0]];
    assign tx_ready_o = ~tx_full & ~tx_clear;
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            tx_wp <= 0;
            tx_rp <= 0;
        end else if (tx_clear) begin
            tx_wp <= 0;
            tx_rp <= 0;
        end else begin
            if (cmd_write_i && !tx_full) begin
                tx_mem[tx_wp[`ITC_FIFO_AW-1:0]] <= cmd_wdata_i;
                tx_wp <= tx_wp + 1'b1;
            end
            if (tx_pop && !tx_empty)
                tx_rp <= tx_rp + 1'b1;
        end
    end
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            rx_wp <= 0;
            rx_rp <= 0;
            rx_data_o <= 8'h00;
        end else if (!enable_i) begin
            rx_wp <= 0;
            rx_rp <= 0;
        end else begin
            if (rx_push && !rx_full) begin
                rx_mem[rx_wp[`ITC_FIFO_AW-1:0]] <= rx_byte;
                rx_wp <= rx_wp + 1'b1;
            end
            if (data_read_i && !rx_empty) begin
                rx_data_o <= rx_mem[rx_rp[`ITC_FIFO_AW-1:0]];
                rx_rp <= rx_rp + 1'b1;
            end
        end
    end
    // Flush request toggled by the engine and resampled here before the FIFO clear
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            flush_s1 <= 1'b0;
            flush_s2 <= 1'b0;
            flush_s3 <= 1'b0;
        end else begin
            flush_s1 <= flush_tgl;
            flush_s2 <= flush_s1;
            flush_s3 <= flush_s2;
        end
    end
    assign status_reg_o = {4'h0, ~rx_empty, 3'h0} | {7'h00, active};
    assign raw_irq_status_reg_o = {1'b0, tx_abort_irq_flag, rd_req, 2'h0, rx_full, 2'h0};
    assign enable_state_reg_o = enable_i | active;
    assign scl_o = 1'b0;
    assign scl_oe_o = scl_low | stretch;
    assign sda_o = 1'b0;
    assign sda_oe_o = drive_sda & ~sda_out;
    // Master and slave engine
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            state <= S_IDLE;
            cnt <= 8'h00;
            nbits <= 4'h0;
            shreg <= 8'h00;
            rx_byte <= 8'h00;
            cur <= 10'h000;
            phase <= 1'b0;
            active <= 1'b0;
            sda_out <= 1'b1;
            drive_sda <= 1'b0;
            scl_low <= 1'b0;
            stretch <= 1'b0;
            is_read <= 1'b0;
            addr_phase <= 1'b0;
            tx_pop <= 1'b0;
            rx_push <= 1'b0;
            rd_req <= 1'b0;
            tx_abort_irq_flag <= 1'b0;
            abort_hold <= 1'b0;
            flush_tgl <= 1'b0;
            abort_req <= 1'b0;
            abort_stop <= 1'b0;
            abort_cause_reg_o <= 17'h00000;
        end else begin
            tx_pop <= 1'b0;
            rx_push <= 1'b0;
            if (abort_i && master && enable_i)
                abort_req <= 1'b1;
            if (rd_req_clear_i)
                rd_req <= 1'b0;
            if (abort_clear_read_i) begin
                tx_abort_irq_flag <= 1'b0;
                abort_hold <= 1'b0;
                abort_cause_reg_o <= 17'h00000;
            end
            cnt <= (cnt == 8'h00) ? 8'h00 : cnt - 1'b1;
            case (state)
            S_IDLE: begin
                active <= 1'b0;
                drive_sda <= 1'b0;
                scl_low <= 1'b0;
                stretch <= 1'b0;
                if (master && enable_i && !tx_empty && !abort_req) begin
                    state <= S_START;
                    active <= 1'b1;
                    drive_sda <= 1'b1;
                    sda_out <= 1'b0;
                    cnt <= HB;
                    addr_phase <= 1'b1;
                    cur <= tx_head;
                    is_read <= tx_head[`ITC_CMD_READ_BIT];
                    shreg <= {target_address_reg_i[6:0], tx_head[`ITC_CMD_READ_BIT]};
                end else if (!master && enable_i && bus_start)
                    state <= S_SADDR;
                else if (abort_req) begin
                    abort_req <= 1'b0;
                    abort_stop <= 1'b1;
                    state <= S_STOP;
                end
            end
            S_START: if (cnt == 8'h00) begin
                scl_low <= 1'b1;
                nbits <= 4'h8;
                phase <= 1'b0;
                cnt <= HB;
                state <= S_BIT;
            end
            S_BIT: begin
                // Data moves only in the middle of SCL low
                if (!phase && cnt == (HB >> 1)) begin
                    drive_sda <= (nbits == 4'h0) ? (is_read & ~addr_phase) : ~(is_read & ~addr_phase);
                    sda_out <= (nbits == 4'h0) ? (cur[`ITC_CMD_STOP_BIT] || tx_empty) : shreg[7];
                end
                // High time counts only once SCL is seen high
                if (phase && !scl)
                    cnt <= HB;
                else if (cnt == 8'h00) begin
                    cnt <= HB;
                    phase <= ~phase;
                    scl_low <= phase;
                    if (phase) begin
                        shreg <= {shreg[6:0], sda};
                        nbits <= nbits - 1'b1;
                    end else if (nbits == 4'h0)
                        state <= S_ACK;
                end
            end
            S_ACK: if (!scl)
                cnt <= HB;
            else if (cnt == 8'h00) begin
                scl_low <= 1'b1;
                cnt <= HB;
                if (is_read && !addr_phase) begin
                    rx_byte <= shreg;
                    rx_push <= 1'b1;
                end
                addr_phase <= 1'b0;
                if (addr_phase && !is_read) begin
                    shreg <= cur[7:0];
                    nbits <= 4'h8;
                    phase <= 1'b0;
                    state <= S_BIT;
                end else if (addr_phase) begin
                    nbits <= 4'h8;
                    phase <= 1'b0;
                    state <= S_BIT;
                end else begin
                    tx_pop <= 1'b1;
                    state <= S_HOLD;
                end
            end
            S_HOLD: if (!tx_pop) begin
                if (abort_req) begin
                    abort_req <= 1'b0;
                    abort_stop <= 1'b1;
                    state <= S_STOP;
                end else if (cur[`ITC_CMD_STOP_BIT]) begin
                    state <= S_STOP;
                end else if (!tx_empty) begin
                    cur <= tx_head;
                    is_read <= tx_head[`ITC_CMD_READ_BIT];
                    shreg <= tx_head[7:0];
                    nbits <= 4'h8;
                    phase <= 1'b0;
                    cnt <= HB;
                    if (tx_head[`ITC_CMD_READ_BIT] != is_read) begin
                        // Free SDA while SCL is still low
                        drive_sda <= 1'b1;
                        sda_out <= 1'b1;
                        state <= S_RSTR;
                    end else
                        state <= S_BIT;
                end
                // Otherwise keep SCL low, even when disabled
            end
            S_RSTR: if (!scl_low && !scl)
                cnt <= HB;
            else if (cnt == 8'h00) begin
                cnt <= HB;
                if (scl_low)
                    scl_low <= 1'b0;
                else begin
                    // SDA falls while SCL high: repeated start
                    sda_out <= 1'b0;
                    addr_phase <= 1'b1;
                    shreg <= {target_address_reg_i[6:0], is_read};
                    state <= S_START;
                end
            end
            S_STOP: begin
                drive_sda <= 1'b1;
                sda_out <= 1'b0;
                if (!scl_low && !scl)
                    cnt <= HB;
                else if (cnt == 8'h00) begin
                    if (scl_low) begin
                        scl_low <= 1'b0;
                        cnt <= HB;
                    end else begin
                        sda_out <= 1'b1;
                        if (abort_stop) begin
                            abort_stop <= 1'b0;
                            tx_abort_irq_flag <= 1'b1;
                            abort_hold <= 1'b1;
                            abort_cause_reg_o[`ITC_CAUSE_SW_BIT] <= 1'b1;
                        end
                        state <= S_IDLE;
                    end
                end
            end
            S_SADDR: if (scl_rise) begin
                shreg <= {shreg[6:0], sda};
                nbits <= nbits + 1'b1;
                if (nbits == 4'h7) begin
                    if ({shreg[5:0], sda} == own_address_reg_i[6:0]) begin
                        is_read <= sda;
                        state <= sda ? S_STX : S_SRX;
                        stretch <= sda & tx_empty;
                        if (sda && tx_empty)
                            rd_req <= 1'b1;
                    end else
                        state <= S_IDLE;
                    nbits <= 4'h0;
                end
            end
            S_SRX: begin
                if (bus_stop || bus_start) begin
                    state <= bus_start ? S_SADDR : S_IDLE;
                    nbits <= 4'h0;
                end else if (scl_rise) begin
                    shreg <= {shreg[6:0], sda};
                    nbits <= nbits + 1'b1;
                    if (nbits == 4'h7) begin
                        rx_byte <= {shreg[6:0], sda};
                        rx_push <= ~rx_full;
                        stretch <= rx_full;
                        nbits <= 4'h0;
                    end
                end else if (stretch && !rx_full) begin
                    rx_push <= 1'b1;
                    stretch <= 1'b0;
                end
            end
            S_STX: begin
                if (stretch && !tx_empty) begin
                    stretch <= 1'b0;
                    rd_req <= 1'b0;
                end
                if (bus_stop || bus_start) begin
                    state <= bus_start ? S_SADDR : S_IDLE;
                    nbits <= 4'h0;
                end else if (scl_fall && !stretch) begin
                    drive_sda <= (nbits != 4'h8);
                    sda_out <= tx_head[7 - nbits[2:0]];
                end else if (scl_rise && !stretch) begin
                    nbits <= nbits + 1'b1;
                    if (nbits == 4'h8) begin
                        nbits <= 4'h0;
                        tx_pop <= 1'b1;
                        if (sda) begin
                            state <= S_SWAIT;
                        end else if (tx_rp + 1'b1 == tx_wp) begin
                            rd_req <= 1'b1;
                            stretch <= 1'b1;
                        end
                    end
                end
            end
            S_SWAIT: if (!tx_pop) begin
                drive_sda <= 1'b0;
                if (!tx_empty) begin
                    flush_tgl <= ~flush_tgl;
                    tx_abort_irq_flag <= 1'b1;
                    abort_hold <= 1'b1;
                end
                state <= S_IDLE;
            end
            default: state <= S_IDLE;
            endcase
        end
    end
endmodule

// File: itc_checker.sv
// Port checker for the I2C transfer controller.
// Assumes binding to itc_core; one clock domain, clk_i with synchronous reset rst_b_i.
module itc_checker (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic [6:0]  control_config_reg_i,
    input wire logic        enable_i,
    input wire logic        data_read_i,
    input wire logic        abort_clear_read_i,
    input wire logic        scl_oe_o,
    input wire logic        sda_oe_o,
    input wire logic [7:0]  status_reg_o,
    input wire logic [7:0]  raw_irq_status_reg_o,
    input wire logic [16:0] abort_cause_reg_o,
    input wire logic        enable_state_reg_o,
    input wire logic        tx_ready_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    off_no_ready_a: assert property (!enable_state_reg_o |-> !tx_ready_o)
        else $error("tx ready while shut down");
    abort_holds_fifo_a: assert property (raw_irq_status_reg_o[6] |-> !tx_ready_o)
        else $error("tx ready while abort pending");
    abort_cause_a: assert property ($rose(abort_cause_reg_o[16]) |-> ##[0:2] raw_irq_status_reg_o[6])
        else $error("software abort cause without abort flag");
    abort_clear_a: assert property (abort_clear_read_i && raw_irq_status_reg_o[6] |=> !raw_irq_status_reg_o[6])
        else $error("abort flag survived its clear");
    rx_pop_a: assert property ($fell(status_reg_o[3]) |-> $past(data_read_i) || !$past(enable_i))
        else $error("rx not empty dropped without a read");
    enable_state_a: assert property ($past(enable_i) && enable_i |-> enable_state_reg_o)
        else $error("enable state low while enabled");
    shutdown_idle_a: assert property ($fell(enable_state_reg_o) |-> !$past(scl_oe_o))
        else $error("shut down while holding the clock");
    start_clock_a: assert property ($rose(sda_oe_o) && !scl_oe_o && control_config_reg_i[0]
                                    |-> ##[1:16] scl_oe_o)
        else $error("start without clocking");
    abort_master_a: assert property ($rose(abort_cause_reg_o[16]) |-> control_config_reg_i[0])
        else $error("software abort outside master mode");
endmodule

bind itc_core itc_checker chk_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .control_config_reg_i(control_config_reg_i), .enable_i(enable_i),
    .data_read_i(data_read_i), .abort_clear_read_i(abort_clear_read_i), .scl_oe_o(scl_oe_o),
    .sda_oe_o(sda_oe_o), .status_reg_o(status_reg_o), .raw_irq_status_reg_o(raw_irq_status_reg_o),
    .abort_cause_reg_o(abort_cause_reg_o), .enable_state_reg_o(enable_state_reg_o), .tx_ready_o(tx_ready_o)
);

// File: itc_partner.sv
// Remote I2C slave: acks address and written bytes, returns a fixed byte on reads.
// Assumes open-drain lines with pull-ups resolved by the bench.
module itc_partner (
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic stretch_i,
    output logic      scl_oe_o,
    output logic      sda_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Bit 7 set so the line is free for the stop after a nack
    logic [7:0] rd_byte = 8'hA5;
    logic [7:0] sh = 8'h00;
    logic       addr_ph = 1'b1;
    logic       data_rd = 1'b0;
    int         bitn = 0;
    logic [7:0] got_q[$];
    initial scl_oe_o = 1'b0;
    initial sda_oe_o = 1'b0;
    always @(negedge sda_i) if (scl_i === 1'b1) begin
        bitn = 0;
        addr_ph = 1'b1;
        data_rd = 1'b0;
    end
    always @(posedge sda_i) if (scl_i === 1'b1) begin
        addr_ph = 1'b1;
        data_rd = 1'b0;
    end
    always @(posedge scl_i) begin
        if (bitn < 8) begin
            sh = {sh[6:0], sda_i};
            bitn++;
            if (bitn == 8 && !data_rd) got_q.push_back(sh);
        end else begin
            bitn = 0;
            if (addr_ph) data_rd = sh[0];
            addr_ph = 1'b0;
        end
    end
    always @(negedge scl_i) begin
        if (bitn == 8) sda_oe_o = !data_rd;
        else sda_oe_o = data_rd && !rd_byte[7 - bitn];
        if (bitn == 0 && stretch_i) begin
            scl_oe_o = 1'b1;
            #400;
            scl_oe_o = 1'b0;
        end
    end
endmodule

// File: tb.sv
// Bench for the I2C transfer controller in master mode against a remote slave model.
// Assumes itc_core with its bound checker; lines resolved here with pull-ups.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [6:0]  cfg = 7'h00;
    logic        enable_i = 1'b0;
    logic        abort_i = 1'b0;
    logic [11:0] tar = 12'h000;
    logic [9:0]  cmd = 10'h000;
    logic        cmd_write_i = 1'b0;
    logic        data_read_i = 1'b0;
    logic        clr_i = 1'b0;
    logic        stretch = 1'b0;
    logic [6:0]  addr7;
    logic [7:0]  exp_q[$];
    logic [9:0]  wq[$];
    int          n_errors = 0;
    int          checks_done = 0;
    wire         scl_oe, sda_oe, p_scl_oe, p_sda_oe, en_state, tx_ready;
    wire         scl = !(scl_oe | p_scl_oe);
    wire         sda = !(sda_oe | p_sda_oe);
    wire [7:0]   rx_data, status, raw;
    wire [16:0]  cause;
    itc_core dut_u (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .control_config_reg_i(cfg), .enable_i(enable_i), .abort_i(abort_i),
        .target_address_reg_i(tar), .own_address_reg_i(10'h000), .cmd_wdata_i(cmd), .cmd_write_i(cmd_write_i),
        .data_read_i(data_read_i), .abort_clear_read_i(clr_i), .rd_req_clear_i(1'b0), .scl_i(scl), .sda_i(sda),
        .scl_o(), .scl_oe_o(scl_oe), .sda_o(), .sda_oe_o(sda_oe), .rx_data_o(rx_data), .status_reg_o(status),
        .raw_irq_status_reg_o(raw), .abort_cause_reg_o(cause), .enable_state_reg_o(en_state), .tx_ready_o(tx_ready)
    );
    itc_partner pu (
        .scl_i(scl), .sda_i(sda), .stretch_i(stretch), .scl_oe_o(p_scl_oe), .sda_oe_o(p_sda_oe)
    );
    initial forever #2.5 clk_i = !clk_i;
    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d of %0d checks", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic wait_until(input int what, input int n);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 4000 && !hit; k++) begin
            case (what)
                0: hit = pu.got_q.size() >= n;
                1: hit = status[0] === 1'b0;
                2: hit = raw[6] === 1'b1;
                3: hit = en_state === 1'b0;
                default: hit = tx_ready === 1'b1;
            endcase
            if (!hit) tick(1);
        end
        if (!hit) begin
            check("wait", what, 99);
            test_done();
        end
    endtask
    // Queued commands go out back to back; the strobe drops only while the fifo refuses
    task automatic send();
        foreach (wq[i]) begin
            if (tx_ready !== 1'b1) begin
                cmd_write_i = 1'b0;
                wait_until(4, 0);
            end
            cmd = wq[i];
            cmd_write_i = 1'b1;
            if (!wq[i][8]) exp_q.push_back(wq[i][7:0]);
            tick(1);
        end
        cmd_write_i = 1'b0;
        wq.delete();
    endtask
    task automatic compare();
        while (exp_q.size() > 0) check("bus byte", pu.got_q.pop_front(), exp_q.pop_front());
    endtask
    initial begin
        #400000;
        check("watchdog", 0, 1);
        test_done();
    end
    initial begin
        void'($urandom(13246));
        addr7 = 7'($urandom);
        tar = {5'h00, addr7};
        cfg = 7'h43;
        tick(4);
        rst_b_i = 1'b1;
        tick(1);
        check("enable state", en_state, 0);
        check("tx ready off", tx_ready, 0);
        cmd = 10'h2C3;
        cmd_write_i = 1'b1;
        tick(1);
        cmd_write_i = 1'b0;
        enable_i = 1'b1;
        tick(40);
        check("lost write scl", scl_oe, 0);
        check("enable state", en_state, 1);
        exp_q.push_back({addr7, 1'b0});
        repeat (3) wq.push_back({2'b00, 8'($urandom)});
        wq.push_back({2'b10, 8'($urandom)});
        send();
        wait_until(0, 5);
        compare();
        wait_until(1, 0);
        check("scl after stop", scl, 1);
        check("sda after stop", sda, 1);
        stretch = 1'b1;
        exp_q.push_back({addr7, 1'b0});
        wq.push_back({2'b00, 8'($urandom)});
        wq.push_back({2'b11, 8'($urandom)});
        send();
        exp_q.push_back({addr7, 1'b1});
        wait_until(0, 3);
        compare();
        wait_until(1, 0);
        stretch = 1'b0;
        check("rx not empty", status[3], 1);
        data_read_i = 1'b1;
        tick(1);
        data_read_i = 1'b0;
        check("rx data", rx_data, pu.rd_byte);
        check("rx drained", status[3], 0);
        exp_q.push_back({addr7, 1'b0});
        wq.push_back({2'b00, 8'($urandom)});
        send();
        wait_until(0, 2);
        compare();
        tick(300);
        check("scl held", scl, 0);
        enable_i = 1'b0;
        tick(300);
        check("still active", en_state, 1);
        check("scl held", scl_oe, 1);
        enable_i = 1'b1;
        abort_i = 1'b1;
        tick(1);
        abort_i = 1'b0;
        wait_until(2, 0);
        check("user abort", cause[16], 1);
        wait_until(1, 0);
        check("stop seen", pu.addr_ph, 1);
        check("sda after abort", sda, 1);
        check("tx held flushed", tx_ready, 0);
        clr_i = 1'b1;
        tick(1);
        clr_i = 1'b0;
        tick(1);
        check("abort flag", raw[6], 0);
        check("tx ready", tx_ready, 1);
        enable_i = 1'b0;
        wait_until(3, 0);
        check("bus idle", scl, 1);
        test_done();
    end
endmodule
